// File: rtl/cmc_pkg.sv
// shared constants and types of the connection command register block
package cmc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000; // one unit of the test length register
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL_B = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_TEST_LEN = 8'h08;
  localparam logic [7:0] OFS_XMIT_VEC = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int B_CMD_LO = 0;
  localparam int B_MAINT = 2;
  localparam int B_LONG = 3;
  localparam int B_JOIN = 4;
  localparam int B_LOOP_LO = 5;
  localparam int B_CLASS = 7;
  localparam int B_MLS_LO = 8;
  localparam int A_SCRUB = 0;
  localparam int A_BYPASS = 1;
  localparam int ST_STATE_LO = 0;
  localparam int ST_LCT = 4;
  localparam int ST_BYPASS = 5;
  localparam int ST_MAINT_PEND = 6;
  localparam int ST_LS_LO = 8;
  localparam logic [15:0] TEST_LEN_RST = 16'h0010;
  localparam int NUM_INT = 4;
  localparam int I_LCT_DONE = 0;
  localparam int I_LCT_ABORT = 1;
  localparam int I_JOIN = 2;
  localparam int I_MAINT = 3;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] LOOP_NONE = 2'h0;
  localparam logic [1:0] LOOP_IDLE = 2'h2;
  localparam logic [1:0] LOOP_REMOTE = 2'h3;
  localparam logic [2:0] MLS_IDLE = 3'h1;
  localparam logic [2:0] MLS_HALT = 3'h2;
  localparam logic [2:0] MLS_MASTER = 3'h3;
  localparam logic [2:0] MLS_DATA = 3'h6;

  typedef enum logic [3:0] {
    PCM_OFF, PCM_BREAK, PCM_TRACE, PCM_CONNECT, PCM_NEXT,
    PCM_SIGNAL, PCM_JOIN, PCM_VERIFY, PCM_ACTIVE, PCM_MAINT
  } cmc_pcm_state_t;

  typedef enum logic [2:0] {
    LS_NORMAL, LS_QUIET, LS_IDLE, LS_HALT, LS_MASTER, LS_DATA
  } cmc_ls_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } cmc_wr_t;

  typedef struct packed {
    logic master;
    logic halt;
  } cmc_line_t;

endpackage

// File: rtl/cmc_ahb_slave.sv
// AHB-Lite slave front end: write strobe and registered read data
`timescale 1ns/10ps
module cmc_ahb_slave
  import cmc_pkg::*;
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [31:0] haddr, // byte address
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic [7:0] rd_addr, // read mux address
  input wire logic [31:0] rd_data, // read mux data
  output cmc_wr_t wr // one-cycle write strobe
);

  typedef struct packed {
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] rdata;
  } cmc_ahb_st_t;

  cmc_ahb_st_t q;
  cmc_ahb_st_t d;
  logic req;
  logic rd_stall;

  // a read right behind a write waits one cycle so it sees the new value
  always_comb
  begin
    rd_stall = q.wpend & hsel & htrans[1] & ~hwrite;
    hreadyout = ~rd_stall;
    req = hsel & htrans[1] & hready;
    rd_addr = haddr[7:0];
    d = q;
    d.wpend = req & hwrite;
    if (req & hwrite)
      d.waddr = haddr[7:0];
    if (req & ~hwrite)
      d.rdata = rd_data;
    wr.en = q.wpend & ce;
    wr.addr = q.waddr;
    wr.data = hwdata;
  end

  assign hrdata = q.rdata;

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

endmodule

// File: rtl/cmc_lct_timer.sv
// link confidence test length timer, counted in prescaled ticks
`timescale 1ns/10ps
module cmc_lct_timer
  import cmc_pkg::*;
#(
  parameter int TICK = TICK_CYCLES, // clock cycles per length unit
  parameter int LEN_W = 16 // width of the length value
)
(
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic start, // load length and run
  input wire logic stop, // cancel a running test
  input wire logic [LEN_W-1:0] length, // test length in ticks
  output logic done // one-cycle pulse at expiry
);

  localparam int PW = $clog2(TICK + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK - 1);

  typedef struct packed {
    logic run;
    logic [PW-1:0] pre;
    logic [LEN_W-1:0] cnt;
    logic done;
  } cmc_tmr_st_t;

  cmc_tmr_st_t q;
  cmc_tmr_st_t d;

  // a zero length still runs one tick so the test is never empty
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (stop)
      d.run = 1'b0;
    else if (start)
    begin
      d.run = 1'b1;
      d.pre = '0;
      d.cnt = length;
    end
    else if (q.run)
    begin
      if (q.pre == PRE_LAST)
      begin
        d.pre = '0;
        if (q.cnt <= LEN_W'(1))
        begin
          d.run = 1'b0;
          d.done = 1'b1;
        end
        else
          d.cnt = q.cnt - LEN_W'(1);
      end
      else
        d.pre = q.pre + PW'(1);
    end
  end

  assign done = q.done;

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

endmodule

// File: rtl/cmc_conn_cmd.sv
// connection management command bits with AHB-Lite registers and interrupt
// Notes on behaviour
// - single-attach flag keeps station unbypassed until ACTIVE, outside maintenance
// - in maintenance, bypass follows bypass select and scrub follows scrub request of control A
// - single-attach flag changes only while manager is OFF
// - nonzero loopback select written in NEXT starts a link confidence test
// - loopback codes: none, transmit data, idle, data plus remote loop
// - loopback writes ignored outside NEXT or while signaling
// - join request in NEXT moves manager to JOIN
// - join writes ignored outside NEXT or while signaling
// - another join needs the bit cleared then set again
// - join during a running test aborts that test
// - long test runs until vector write, join, other command or leaving NEXT
// - short test ends after the programmed test length
// - neighbour master or halt line state stops any test
// - maintenance request while OFF moves manager to MAINT
// - pending maintenance request acts on the later arrival in OFF
// - maintenance line state code selects idle, halt, master, data or quiet
`timescale 1ns/10ps
module cmc_conn_cmd
  import cmc_pkg::*;
#(
  parameter int TICK = TICK_CYCLES // clock cycles per test length unit
)
(
  input wire logic hclk, // bus clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire cmc_pcm_state_t pcm_state, // connection manager state
  input wire logic pcm_signaling, // signaling in progress
  input wire cmc_line_t line, // neighbour line state detected
  input wire logic pcm_bypass_req, // manager's own bypass wish
  output logic join_go, // pulse: enter JOIN
  output logic maint_go, // pulse: enter MAINT
  output logic lct_active, // link confidence test running
  output cmc_ls_t tx_ls, // line state to source
  output logic remote_loop, // remote loop path enabled
  output logic bypass, // station bypass control
  output logic scrub, // scrub request to bypass logic
  output logic irq // interrupt, active high level
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic class_s;
    logic [1:0] loop;
    logic join_req;
    logic long_test;
    logic maint_req;
    logic [2:0] maintenance_line_state;
    logic [1:0] cmd;
    logic scrub_req;
    logic bypass_sel;
    logic [15:0] test_len;
    logic [15:0] xvec;
    logic loop_armed;
    logic join_armed;
    logic lct_on;
    logic [1:0] lct_mode;
    logic lct_start;
    logic maint_done;
    logic join_go;
    logic maint_go;
    logic [NUM_INT-1:0] int_st;
    logic [NUM_INT-1:0] int_mask;
    logic bypass;
    logic scrub;
    cmc_ls_t tx_ls;
    logic remote_loop;
    logic irq;
  } cmc_main_st_t;

  localparam cmc_main_st_t ST_RST = '{
    test_len: TEST_LEN_RST, loop_armed: 1'b1, join_armed: 1'b1,
    tx_ls: LS_NORMAL, default: '0};

  cmc_main_st_t q;
  cmc_main_st_t d;
  cmc_wr_t wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic tmr_done;
  logic wr_b;
  logic in_next;
  logic loop_ok;
  logic join_ok;
  logic join_fire;
  logic long_end;
  logic line_stop;
  logic [1:0] wloop;
  logic [NUM_INT-1:0] ev;
  logic [NUM_INT-1:0] clr;

  // true when the write strobe targets the given offset
  function automatic logic wr_hit(input cmc_wr_t w, input logic [7:0] ofs);
    wr_hit = w.en && (w.addr == ofs);
  endfunction

  // maintenance line state code to source selection
  function automatic cmc_ls_t mls_decode(input logic [2:0] code);
    unique case (code)
      MLS_IDLE: mls_decode = LS_IDLE;
      MLS_HALT: mls_decode = LS_HALT;
      MLS_MASTER: mls_decode = LS_MASTER;
      MLS_DATA: mls_decode = LS_DATA;
      default: mls_decode = LS_QUIET;
    endcase
  endfunction

  // ****************************************************************
  // bus slave and test timer
  // ****************************************************************
  cmc_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .haddr(haddr),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr(wr)
  );

  // timer is loaded one cycle after the start and dropped when the test ends
  cmc_lct_timer #(.TICK(TICK), .LEN_W(16)) u_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(q.lct_start),
    .stop(~q.lct_on),
    .length(q.test_len),
    .done(tmr_done)
  );

  assign hresp = 1'b0;

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unmapped offsets read zero; hsize is not checked, every access is a word
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      OFS_CTRL_B: rd_data[15:0] = {5'h00, q.maintenance_line_state, q.class_s, q.loop,
                                   q.join_req, q.long_test, q.maint_req, q.cmd};
      OFS_CTRL_A: rd_data[1:0] = {q.bypass_sel, q.scrub_req};
      OFS_TEST_LEN: rd_data[15:0] = q.test_len;
      OFS_XMIT_VEC: rd_data[15:0] = q.xvec;
      OFS_STATUS:
      begin
        rd_data[ST_STATE_LO +: 4] = pcm_state;
        rd_data[ST_LCT] = q.lct_on;
        rd_data[ST_BYPASS] = q.bypass;
        rd_data[ST_MAINT_PEND] = q.maint_req & ~q.maint_done;
        rd_data[ST_LS_LO +: 3] = q.tx_ls;
      end
      OFS_INT_STAT: rd_data[NUM_INT-1:0] = q.int_st;
      OFS_INT_MASK: rd_data[NUM_INT-1:0] = q.int_mask;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // command logic
  // ****************************************************************
  // loopback and join are only honoured in NEXT with no signaling going on
  always_comb
  begin
    wr_b = wr_hit(wr, OFS_CTRL_B);
    wloop = wr.data[B_LOOP_LO +: 2];
    in_next = (pcm_state == PCM_NEXT) && !pcm_signaling;
    loop_ok = wr_b && in_next;
    join_ok = wr_b && in_next;
    join_fire = join_ok && wr.data[B_JOIN] && q.join_armed;
    line_stop = line.master | line.halt;
    long_end = wr_hit(wr, OFS_XMIT_VEC) || (wr_b && (wr.data[B_CMD_LO +: 2] != 2'h0))
               || (pcm_state != PCM_NEXT);
    ev = '0;
    d = q;
    d.lct_start = 1'b0;

    // plain register fields
    if (wr_b)
    begin
      d.long_test = wr.data[B_LONG];
      d.maint_req = wr.data[B_MAINT];
      d.maintenance_line_state = wr.data[B_MLS_LO +: 3];
      d.cmd = wr.data[B_CMD_LO +: 2];
      if (pcm_state == PCM_OFF)
        d.class_s = wr.data[B_CLASS];
      if (wloop == LOOP_NONE)
        d.loop_armed = 1'b1;
      if (!wr.data[B_JOIN])
        d.join_armed = 1'b1;
      if (loop_ok)
        d.loop = wloop;
      if (join_ok)
        d.join_req = wr.data[B_JOIN];
    end
    if (wr_hit(wr, OFS_CTRL_A))
      {d.bypass_sel, d.scrub_req} = {wr.data[A_BYPASS], wr.data[A_SCRUB]};
    if (wr_hit(wr, OFS_TEST_LEN))
      d.test_len = wr.data[15:0];
    if (wr_hit(wr, OFS_XMIT_VEC))
      d.xvec = wr.data[15:0];
    if (wr_hit(wr, OFS_INT_MASK))
      d.int_mask = wr.data[NUM_INT-1:0];

    // test end: join aborts, commands and leaving NEXT abort, line or timer finish
    if (q.lct_on)
    begin
      ev[I_LCT_ABORT] = join_fire || (!line_stop && long_end);
      ev[I_LCT_DONE] = !join_fire && (line_stop || (!long_end && tmr_done && !q.long_test));
      d.lct_on = !(ev[I_LCT_ABORT] || ev[I_LCT_DONE]);
    end
    // a test only starts from an armed field, so a held value never retriggers
    else if (loop_ok && (wloop != LOOP_NONE) && q.loop_armed && !join_fire)
    begin
      d.lct_on = 1'b1;
      d.lct_mode = wloop;
      d.lct_start = 1'b1;
      d.loop_armed = 1'b0;
    end

    // join request
    d.join_go = join_fire;
    ev[I_JOIN] = join_fire;
    if (join_fire)
      d.join_armed = 1'b0;

    // maintenance entry, once per arrival in OFF while the request stands
    d.maint_go = q.maint_req && (pcm_state == PCM_OFF) && !q.maint_done;
    ev[I_MAINT] = d.maint_go;
    d.maint_done = q.maint_req && (pcm_state == PCM_OFF);

    // bypass control: maintenance hands it to control A, else single-attach holds it off
    d.scrub = (pcm_state == PCM_MAINT) && q.scrub_req;
    if (pcm_state == PCM_MAINT)
      d.bypass = q.bypass_sel;
    else if (q.class_s && (pcm_state != PCM_ACTIVE))
      d.bypass = 1'b0;
    else
      d.bypass = pcm_bypass_req;

    // line state source
    if (pcm_state == PCM_MAINT)
      d.tx_ls = mls_decode(q.maintenance_line_state);
    else if (q.lct_on)
      d.tx_ls = (q.lct_mode == LOOP_IDLE) ? LS_IDLE : LS_DATA;
    else
      d.tx_ls = LS_NORMAL;
    d.remote_loop = q.lct_on && (q.lct_mode == LOOP_REMOTE) && (pcm_state != PCM_MAINT);

    // sticky interrupt status: an event in the clearing cycle survives
    clr = wr_hit(wr, OFS_INT_STAT) ? wr.data[NUM_INT-1:0] : '0;
    d.int_st = (q.int_st & ~clr) | ev;
    d.irq = |(d.int_st & d.int_mask);
  end

  // state register, reset loads TEST_LEN_RST and sets both arm flags, everything else cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= ST_RST;
    else if (ce)
      q <= d;
  end

  assign join_go = q.join_go;
  assign maint_go = q.maint_go;
  assign lct_active = q.lct_on;
  assign tx_ls = q.tx_ls;
  assign remote_loop = q.remote_loop;
  assign bypass = q.bypass;
  assign scrub = q.scrub;
  assign irq = q.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_class_hold;
    ce && q.class_s && (pcm_state != PCM_ACTIVE) && (pcm_state != PCM_MAINT) |=> !bypass;
  endproperty
  a_class_hold: assert property (p_class_hold) else $error("bypass before active");
  property p_maint_bypass;
    ce && (pcm_state == PCM_MAINT) |=> (bypass == $past(q.bypass_sel)) && (scrub == $past(q.scrub_req));
  endproperty
  a_maint_bypass: assert property (p_maint_bypass) else $error("maint bypass wrong");
  property p_class_lock;
    ce && wr_b && (pcm_state != PCM_OFF) |=> $stable(q.class_s);
  endproperty
  a_class_lock: assert property (p_class_lock) else $error("class flag changed");
  property p_lct_start;
    ce && loop_ok && (wloop != LOOP_NONE) && q.loop_armed && !q.lct_on && !join_fire
      |=> lct_active ##1 (tx_ls == ((q.lct_mode == LOOP_IDLE) ? LS_IDLE : LS_DATA));
  endproperty
  a_lct_start: assert property (p_lct_start) else $error("test not started");
  property p_loop_ignore;
    ce && wr_b && !in_next |=> $stable(q.loop) && $stable(q.join_req);
  endproperty
  a_loop_ignore: assert property (p_loop_ignore) else $error("write not ignored");
  property p_no_restart;
    $rose(q.lct_start) |-> $past(q.loop_armed) && !q.loop_armed;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("test restarted");
  property p_join_go;
    ce && join_fire |=> join_go ##1 !join_go;
  endproperty
  a_join_go: assert property (p_join_go) else $error("join pulse wrong");
  property p_join_held;
    ce && join_ok && !q.join_armed |=> !join_go;
  endproperty
  a_join_held: assert property (p_join_held) else $error("join on held bit");
  property p_join_abort;
    ce && q.lct_on && join_fire |=> !lct_active && q.int_st[I_LCT_ABORT];
  endproperty
  a_join_abort: assert property (p_join_abort) else $error("test not aborted");
  property p_long_runs;
    ce && q.lct_on && q.long_test && !long_end && !line_stop && !join_fire |=> lct_active;
  endproperty
  a_long_runs: assert property (p_long_runs) else $error("long test ended");
  property p_line_stop;
    ce && q.lct_on && line_stop |=> !lct_active;
  endproperty
  a_line_stop: assert property (p_line_stop) else $error("test ran on");
  property p_maint_go;
    ce && q.maint_req && (pcm_state == PCM_OFF) && !q.maint_done |=> maint_go;
  endproperty
  a_maint_go: assert property (p_maint_go) else $error("no maint entry");
  property p_maintenance_line_state;
    ce && (pcm_state == PCM_MAINT) && (q.maintenance_line_state == MLS_HALT) |=> (tx_ls == LS_HALT);
  endproperty
  a_maintenance_line_state: assert property (p_maintenance_line_state) else $error("maint line state wrong");

  c_lct_done: cover property (q.lct_on ##1 q.int_st[I_LCT_DONE]);
  c_join: cover property (join_go);
  c_maint: cover property (maint_go);

endmodule

// File: sim/cmc_conn_cmd_tb.sv
// self-checking testbench of the connection command register block
`timescale 1ns/10ps
module cmc_conn_cmd_tb;
  import cmc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  cmc_pcm_state_t pcm_state = PCM_OFF;
  logic pcm_signaling = 1'b0;
  cmc_line_t line = '0;
  logic pcm_bypass_req = 1'b0;
  logic hreadyout, hresp, join_go, maint_go, lct_active, remote_loop, bypass, scrub, irq;
  logic [31:0] hrdata, rd;
  cmc_ls_t tx_ls;
  int error_cnt = 0;
  int num_checks = 0;
  int join_n = 0;
  int maint_n = 0;
  cmc_ls_t mls_exp [8] = '{LS_QUIET, LS_IDLE, LS_HALT, LS_MASTER, LS_QUIET, LS_QUIET, LS_DATA,
    LS_QUIET};
  cmc_ls_t loop_exp [4] = '{LS_NORMAL, LS_DATA, LS_IDLE, LS_DATA};

  // short tick keeps the test length at 32 cycles
  cmc_conn_cmd #(.TICK(2)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pcm_state(pcm_state), .pcm_signaling(pcm_signaling), .line(line),
    .pcm_bypass_req(pcm_bypass_req), .join_go(join_go), .maint_go(maint_go),
    .lct_active(lct_active), .tx_ls(tx_ls), .remote_loop(remote_loop), .bypass(bypass),
    .scrub(scrub), .irq(irq));

  always #5 hclk = ~hclk;

  // pulses are counted so that checks need not hit the exact cycle
  always @(posedge hclk)
  begin
    if (join_go === 1'b1) join_n++;
    if (maint_go === 1'b1) maint_n++;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hready is sampled mid-cycle; it is combinational and settled there
  task automatic wait_rdy(output logic [31:0] dat);
    logic r;
    for (int n = 0; n < 20; n++)
    begin
      @(negedge hclk);
      r = hreadyout;
      dat = hrdata;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    error_cnt++;
    report_and_stop();
  endtask

  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rdat);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy(rdat);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rdat); // read data is what stood at the edge that ended the data phase
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
    repeat (3) @(negedge hclk);
  endtask

  task automatic set_pcm(cmc_pcm_state_t s, logic sig);
    @(posedge hclk);
    pcm_state <= s;
    pcm_signaling <= sig;
    repeat (3) @(negedge hclk);
  endtask

  task automatic wait_lct_low(int max);
    for (int n = 0; n < max; n++)
    begin
      @(negedge hclk);
      if (lct_active === 1'b0) return;
    end
    chk("lct end", 0, {31'h0, lct_active});
    report_and_stop();
  endtask

  task automatic t_reset_regs();
    bus(1'b0, OFS_CTRL_B, 0, rd); chk("ctrl_b rst", 0, rd);
    bus(1'b0, OFS_TEST_LEN, 0, rd); chk("len rst", {16'h0, TEST_LEN_RST}, rd);
    bus(1'b0, 8'h1C, 0, rd); chk("unmapped", 0, rd);
    chk("hresp", 0, {31'h0, hresp});
  endtask

  task automatic t_class();
    set_pcm(PCM_NEXT, 1'b0);
    wr(OFS_CTRL_B, 32'h80);
    bus(1'b0, OFS_CTRL_B, 0, rd); chk("class held", 0, rd & 32'h80);
    set_pcm(PCM_OFF, 1'b0);
    wr(OFS_CTRL_B, 32'h80);
    bus(1'b0, OFS_CTRL_B, 0, rd); chk("class set", 32'h80, rd & 32'h80);
    pcm_bypass_req <= 1'b1;
    set_pcm(PCM_NEXT, 1'b0);
    chk("no bypass", 0, {31'h0, bypass});
  endtask

  task automatic t_join();
    set_pcm(PCM_NEXT, 1'b1);
    wr(OFS_CTRL_B, 32'h10); chk("join sig", 0, join_n);
    set_pcm(PCM_NEXT, 1'b0);
    wr(OFS_CTRL_B, 32'h10); chk("join go", 1, join_n);
    wr(OFS_CTRL_B, 32'h10); chk("join held", 1, join_n);
    wr(OFS_CTRL_B, 0);
    wr(OFS_CTRL_B, 32'h10); chk("join again", 2, join_n);
    wr(OFS_CTRL_B, 0);
  endtask

  // each code is ended a different way: timer, neighbour halt, join
  task automatic t_loop();
    for (int c = 1; c < 4; c++)
    begin
      wr(OFS_CTRL_B, c << 5);
      chk("lct on", 1, {31'h0, lct_active});
      chk("tx_ls", {29'h0, loop_exp[c]}, {29'h0, tx_ls});
      chk("rloop", {31'h0, c == 3}, {31'h0, remote_loop});
      if (c == 1)
      begin
        repeat (20) @(negedge hclk);
        chk("short run", 1, {31'h0, lct_active});
        wait_lct_low(30);
        wr(OFS_CTRL_B, c << 5); chk("held loop", 0, {31'h0, lct_active});
      end
      else if (c == 2)
      begin
        @(posedge hclk);
        line <= 2'b01;
        wait_lct_low(4);
        @(posedge hclk);
        line <= 2'b00;
      end
      else
      begin
        wr(OFS_CTRL_B, (c << 5) | 32'h10); chk("abort", 0, {31'h0, lct_active});
      end
      wr(OFS_CTRL_B, 0);
    end
    wr(OFS_CTRL_B, 32'h48);
    repeat (45) @(negedge hclk);
    chk("long run", 1, {31'h0, lct_active});
    wr(OFS_XMIT_VEC, 32'h5); chk("vec end", 0, {31'h0, lct_active});
    wr(OFS_CTRL_B, 0);
    set_pcm(PCM_CONNECT, 1'b0);
    wr(OFS_CTRL_B, 32'h40); chk("loop state", 0, {31'h0, lct_active});
  endtask

  task automatic t_maint();
    wr(OFS_CTRL_B, 32'h04); chk("maint wait", 0, maint_n);
    set_pcm(PCM_OFF, 1'b0); chk("maint go", 1, maint_n);
    set_pcm(PCM_MAINT, 1'b0);
    for (int m = 0; m < 8; m++)
    begin
      wr(OFS_CTRL_B, (m << 8) | 32'h04);
      chk("mls", {29'h0, mls_exp[m]}, {29'h0, tx_ls});
    end
    wr(OFS_CTRL_A, 32'h2); chk("byp a", 1, {31'h0, bypass});
    wr(OFS_CTRL_A, 32'h1); chk("byp off", 0, {31'h0, bypass});
    chk("scrub", 1, {31'h0, scrub});
  endtask

  task automatic t_irq();
    bus(1'b0, OFS_INT_STAT, 0, rd); chk("int stat", 32'hF, rd);
    wr(OFS_INT_MASK, 0); chk("irq mask", 0, {31'h0, irq});
    wr(OFS_INT_MASK, 32'h1 << I_JOIN); chk("irq on", 1, {31'h0, irq});
    bus(1'b0, OFS_INT_MASK, 0, rd); chk("mask rd", 32'h1 << I_JOIN, rd);
    wr(OFS_INT_STAT, 32'hF); chk("irq clr", 0, {31'h0, irq});
    bus(1'b0, OFS_INT_STAT, 0, rd); chk("stat clr", 0, rd);
  endtask

  // reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_regs();
    t_class();
    t_join();
    t_loop();
    t_maint();
    t_irq();
    report_and_stop();
  end
endmodule
